// ===== hw/fpcl_device.sv
// configurable device end: power-on delay, parallel word intake, init
// assumes link pins arrive asynchronously; host obeys clock ratio rules
`timescale 1ns/100ps
module fpcl_device #(
    parameter int unsigned POR_FAST_CYC = fpcl_pkg::POR_FAST_CYC,
    parameter int unsigned POR_STD_CYC = fpcl_pkg::POR_STD_CYC,
    parameter int unsigned OSC_INIT_CYC = fpcl_pkg::OSC_INIT_CYC,
    parameter int unsigned USR_INIT_EDGES = fpcl_pkg::USR_INIT_EDGES,
    parameter bit CHAIN_USED = 1'b0
) (
    input wire logic CORE_CLK_IN,
    input wire logic RESET_IN,
    fpcl_link_if.dev LINK,
    input wire logic [2:0] MODE_SELECT_IN,
    input wire logic COMPRESS_IN,
    input wire logic SECURE_IN,
    input wire logic [fpcl_pkg::WORD_W-1:0] CONFIG_WORDS_IN,
    output logic [fpcl_pkg::WORD_W-1:0] WORD_OUT,
    output logic WORD_VALID_OUT,
    input wire logic WORD_READY_IN,
    output logic USER_MODE_OUT,
    output logic ERROR_OUT,
    output logic [fpcl_pkg::WORD_W-1:0] USER_IO_OUT
);
    import fpcl_pkg::*;

    typedef enum logic [2:0] {
        ST_POR,
        ST_RECONF,
        ST_LOAD,
        ST_DONE,
        ST_INIT,
        ST_USER,
        ST_ERROR
    } fpcl_dev_state_t;

    fpcl_dev_state_t state_q;
    logic [SYNC_W-1:0] s1_q;
    logic [SYNC_W-1:0] s2_q;
    logic [SYNC_W-1:0] s3_q;
    logic [SYNC_W-1:0] f_q;
    logic [SYNC_W-1:0] f_prev_q;
    logic [2:0] mode_q;
    logic compress_q;
    logic secure_q;
    logic [1:0] opt_q;
    logic [31:0] cnt_q;
    logic [31:0] words_q;
    logic [3:0] ratio_q;
    logic [3:0] ratio_lim;
    logic [31:0] por_lim;
    logic [WORD_W-1:0] word_masked;
    logic cfg_rise;
    logic cfg_fall;
    logic uclk_rise;
    logic req_n;
    logic take;
    logic buf_ready;
    logic overrun;
    logic last_done;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: a change counts once stages two and three agree
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (RESET_IN)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            f_q <= '0;
            f_prev_q <= '0;
        end
        else
        begin
            s1_q <= {LINK.init_clock, LINK.reconfig_request_n, LINK.config_clock, LINK.data};
            s2_q <= s1_q;
            s3_q <= s2_q;
            f_q <= ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & f_q);
            f_prev_q <= f_q;
        end
    end

    // edge events on the filtered link signals
    assign cfg_rise = f_q[SY_CCLK] && !f_prev_q[SY_CCLK];
    assign cfg_fall = !f_q[SY_CCLK] && f_prev_q[SY_CCLK];
    assign uclk_rise = f_q[SY_UCLK] && !f_prev_q[SY_UCLK];
    assign req_n = f_q[SY_REQ];

    ////////////////////////////////////////////////////////////////////////
    // straps are captured while waiting, i.e. in the power-on delay and in reconfiguration
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (RESET_IN)
        begin
            mode_q <= 3'h0;
            compress_q <= 1'b0;
            secure_q <= 1'b0;
        end
        else if (state_q == ST_POR || state_q == ST_RECONF)
        begin
            mode_q <= MODE_SELECT_IN;
            compress_q <= COMPRESS_IN;
            secure_q <= SECURE_IN;
        end
    end

    // delay choice and per-word clock ratio
    assign por_lim = mode_q[MODE_FAST_BIT] ? POR_FAST_CYC : POR_STD_CYC;
    assign ratio_lim = clk_ratio(compress_q, secure_q);
    assign word_masked = f_q[WORD_W-1:0] & width_mask(mode_q[MODE_WIDTH_LSB +: 2]);

    // a word is taken on a rising clock once the previous word's extra clocks are spent
    assign take = (state_q == ST_LOAD) && cfg_rise && (ratio_q == 4'h0);
    assign overrun = take && !buf_ready;
    assign last_done = (state_q == ST_LOAD) && (words_q != '0) && (words_q == CONFIG_WORDS_IN)
        && (ratio_q == 4'h0);

    ////////////////////////////////////////////////////////////////////////
    // word intake: counts words, spends ratio-1 clocks after each, keeps options
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (RESET_IN || state_q == ST_POR || state_q == ST_RECONF)
        begin
            words_q <= '0;
            ratio_q <= 4'h0;
            opt_q <= 2'h0;
        end
        else if (take)
        begin
            words_q <= words_q + 32'h0000_0001;
            ratio_q <= ratio_lim - 4'h1;
            if (words_q == '0)
                opt_q <= word_masked[1:0];
        end
        else if (state_q == ST_LOAD && cfg_rise)
        begin
            ratio_q <= ratio_q - 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence from power-on through load and init to user mode
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (RESET_IN)
        begin
            state_q <= ST_POR;
            cnt_q <= '0;
        end
        else if (state_q != ST_POR && state_q != ST_RECONF && !req_n)
        begin
            state_q <= ST_RECONF;
            cnt_q <= '0;
        end
        else
        begin
            unique case (state_q)
                ST_POR:
                begin
                    cnt_q <= cnt_q + 32'h0000_0001;
                    if (cnt_q + 32'h0000_0001 >= por_lim)
                    begin
                        state_q <= ST_LOAD;
                        cnt_q <= '0;
                    end
                end
                ST_RECONF:
                begin
                    if (req_n)
                        state_q <= ST_LOAD;
                end
                ST_LOAD:
                begin
                    if (overrun)
                        state_q <= ST_ERROR;
                    else if (last_done)
                        state_q <= ST_DONE;
                end
                ST_DONE:
                begin
                    if (cfg_fall)
                    begin
                        cnt_q <= cnt_q + 32'h0000_0001;
                        if (cnt_q == FALLS_TO_INIT - 1)
                        begin
                            state_q <= ST_INIT;
                            cnt_q <= '0;
                        end
                    end
                end
                ST_INIT:
                begin
                    if (opt_q[OPT_USRCLK_BIT])
                    begin
                        if (uclk_rise)
                        begin
                            cnt_q <= cnt_q + 32'h0000_0001;
                            if (cnt_q == USR_INIT_EDGES - 1)
                                state_q <= ST_USER;
                        end
                    end
                    else
                    begin
                        cnt_q <= cnt_q + 32'h0000_0001;
                        if (cnt_q == OSC_INIT_CYC - 1)
                            state_q <= ST_USER;
                    end
                end
                ST_USER:
                begin
                    state_q <= ST_USER;
                end
                ST_ERROR:
                begin
                    state_q <= ST_ERROR;
                end
                default:
                begin
                    state_q <= ST_ERROR;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // taken words pass a two-entry buffer; a take while it is full is an overrun and sends the device to error
    fpcl_pair_buf #(
        .WIDTH(WORD_W),
        .DEPTH(2)
    ) u_buf (
        .clk_in(CORE_CLK_IN),
        .reset_in(RESET_IN),
        .in_valid_in(take),
        .in_data_in(word_masked),
        .in_ready_out(buf_ready),
        .out_valid_out(WORD_VALID_OUT),
        .out_data_out(WORD_OUT),
        .out_ready_in(WORD_READY_IN)
    );

    // data lines are handed to user logic once in user mode
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (RESET_IN)
            USER_IO_OUT <= '0;
        else if (state_q == ST_USER)
            USER_IO_OUT <= f_q[WORD_W-1:0];
        else
            USER_IO_OUT <= '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // link pin drive decoded from state, the init-done option bit and CHAIN_USED
    assign LINK.status_drv = 1'b0;
    assign LINK.status_oe = (state_q == ST_POR) || (state_q == ST_RECONF)
        || (state_q == ST_ERROR);
    assign LINK.load_complete = (state_q == ST_DONE) || (state_q == ST_INIT)
        || (state_q == ST_USER);
    assign LINK.init_done_drv = 1'b0;
    assign LINK.init_done_oe = opt_q[OPT_INITDONE_BIT] && ((state_q == ST_LOAD)
        || (state_q == ST_DONE) || (state_q == ST_INIT));
    assign LINK.chain_drv = !LINK.load_complete;
    assign LINK.chain_oe = CHAIN_USED;
    assign USER_MODE_OUT = (state_q == ST_USER);
    assign ERROR_OUT = (state_q == ST_ERROR);
endmodule

// ===== hw/fpcl_host.sv
// configuration host end: request, clock divider, word feeding, init clock
// assumes a word source with valid/ready on the core clock
`timescale 1ns/100ps
module fpcl_host #(
    parameter int unsigned HALF_CYC = fpcl_pkg::HOST_HALF_CYC
) (
    input wire logic CORE_CLK_IN,
    input wire logic RESET_IN,
    fpcl_link_if.host LINK,
    input wire logic START_IN,
    input wire logic COMPRESS_IN,
    input wire logic SECURE_IN,
    input wire logic [1:0] WIDTH_IN,
    input wire logic [fpcl_pkg::WORD_W-1:0] WORD_IN,
    input wire logic WORD_LAST_IN,
    input wire logic WORD_VALID_IN,
    output logic WORD_READY_OUT,
    output logic BUSY_OUT,
    output logic DONE_OUT,
    output logic FAULT_OUT
);
    import fpcl_pkg::*;

    typedef enum logic [2:0] {
        H_IDLE,
        H_REQ,
        H_WAIT,
        H_DATA,
        H_CLK,
        H_WAIT_CD,
        H_FALLS,
        H_USER
    } fpcl_host_state_t;

    fpcl_host_state_t state_q;
    logic [1:0] s1_q;
    logic [1:0] s2_q;
    logic [1:0] s3_q;
    logic [1:0] f_q;
    logic [31:0] div_q;
    logic [31:0] ucnt_q;
    logic [31:0] udiv_q;
    logic [3:0] cyc_q;
    logic clk_q;
    logic uclk_q;
    logic uen_q;
    logic last_q;
    logic [WORD_W-1:0] data_q;
    logic run;
    logic wrap;
    logic fall_ev;
    logic status_hi;
    logic done_hi;

    ////////////////////////////////////////////////////////////////////////
    // status and load-complete synchronisers
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (RESET_IN)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            f_q <= '0;
        end
        else
        begin
            s1_q <= {LINK.load_complete, LINK.status_n};
            s2_q <= s1_q;
            s3_q <= s2_q;
            f_q <= ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & f_q);
        end
    end
    assign status_hi = f_q[0];
    assign done_hi = f_q[1];

    ////////////////////////////////////////////////////////////////////////
    // configuration clock divider; parked low while not running
    assign run = (state_q == H_CLK) || (state_q == H_FALLS);
    assign wrap = run && (div_q == HALF_CYC - 1);
    assign fall_ev = wrap && clk_q;
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (RESET_IN || !run)
        begin
            div_q <= '0;
            clk_q <= 1'b0;
        end
        else if (wrap)
        begin
            div_q <= '0;
            clk_q <= !clk_q;
        end
        else
        begin
            div_q <= div_q + 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequence: request, wait ready, feed words, two closing falls
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (RESET_IN)
        begin
            state_q <= H_IDLE;
            cyc_q <= 4'h0;
            last_q <= 1'b0;
            data_q <= '0;
            FAULT_OUT <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                H_IDLE:
                begin
                    if (START_IN)
                    begin
                        state_q <= H_REQ;
                        FAULT_OUT <= 1'b0;
                    end
                end
                H_REQ:
                begin
                    if (!status_hi)
                        state_q <= H_WAIT;
                end
                H_WAIT:
                begin
                    if (status_hi)
                        state_q <= H_DATA;
                end
                H_DATA:
                begin
                    if (WORD_VALID_IN)
                    begin
                        data_q <= WORD_IN & width_mask(WIDTH_IN);
                        last_q <= WORD_LAST_IN;
                        cyc_q <= clk_ratio(COMPRESS_IN, SECURE_IN);
                        state_q <= H_CLK;
                    end
                end
                H_CLK:
                begin
                    if (!status_hi)
                    begin
                        state_q <= H_IDLE;
                        FAULT_OUT <= 1'b1;
                    end
                    else if (fall_ev)
                    begin
                        cyc_q <= cyc_q - 4'h1;
                        if (cyc_q == 4'h1)
                            state_q <= last_q ? H_WAIT_CD : H_DATA;
                    end
                end
                H_WAIT_CD:
                begin
                    cyc_q <= 4'(FALLS_TO_INIT);
                    if (done_hi)
                        state_q <= H_FALLS;
                end
                H_FALLS:
                begin
                    if (fall_ev)
                    begin
                        cyc_q <= cyc_q - 4'h1;
                        if (cyc_q == 4'h1)
                            state_q <= H_USER;
                    end
                end
                H_USER:
                begin
                    if (START_IN)
                        state_q <= H_REQ;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // user init clock starts only after four configuration clock periods
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (RESET_IN || state_q == H_REQ)
        begin
            ucnt_q <= '0;
            udiv_q <= '0;
            uen_q <= 1'b0;
            uclk_q <= 1'b0;
        end
        else if (!uen_q)
        begin
            if (done_hi)
                ucnt_q <= ucnt_q + 32'h0000_0001;
            if (ucnt_q == UCLK_WAIT_PERIODS * 2 * HALF_CYC)
                uen_q <= 1'b1;
        end
        else if (udiv_q == HALF_CYC - 1)
        begin
            udiv_q <= '0;
            uclk_q <= !uclk_q;
        end
        else
        begin
            udiv_q <= udiv_q + 32'h0000_0001;
        end
    end

    // pin and user-side drive
    assign LINK.config_clock = clk_q;
    assign LINK.init_clock = uclk_q;
    assign LINK.data = data_q;
    assign LINK.reconfig_request_n = (state_q != H_REQ);
    assign WORD_READY_OUT = (state_q == H_DATA);
    assign BUSY_OUT = (state_q != H_IDLE) && (state_q != H_USER);
    assign DONE_OUT = (state_q == H_USER);
endmodule

// ===== hw/fpcl_link_if.sv
// link between configuration host and configurable device
// assumes pull-ups on the open-drain status, init-done and chain lines
`timescale 1ns/100ps
interface fpcl_link_if;
    logic config_clock;
    logic reconfig_request_n;
    logic init_clock;
    logic [31:0] data;
    logic load_complete;
    logic status_drv;
    logic status_oe;
    logic init_done_drv;
    logic init_done_oe;
    logic chain_drv;
    logic chain_oe;
    logic status_n;
    logic init_done_n;
    logic chain_enable_out_n;

    // open-drain lines resolve to high when nobody drives them
    assign status_n = status_oe ? status_drv : 1'b1;
    assign init_done_n = init_done_oe ? init_done_drv : 1'b1;
    assign chain_enable_out_n = chain_oe ? chain_drv : 1'b1;

    modport dev (
        input config_clock, reconfig_request_n, init_clock, data,
        output load_complete, status_drv, status_oe, init_done_drv, init_done_oe,
        output chain_drv, chain_oe
    );
    modport host (
        output config_clock, reconfig_request_n, init_clock, data,
        input load_complete, status_n, init_done_n, chain_enable_out_n
    );
endinterface

// ===== hw/fpcl_pair_buf.sv
// small word buffer with valid/ready on both sides
// assumes depth is a power of two; one clock domain
`timescale 1ns/100ps
module fpcl_pair_buf #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 2
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [PW:0] fill_q;
    logic push;
    logic pop;

    // handshakes and read port
    assign in_ready_out = (fill_q != FULL);
    assign out_valid_out = (fill_q != '0);
    assign out_data_out = mem_q[rd_q];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    // storage array, written only on an accepted push
    always_ff @(posedge clk_in)
    begin
        if (push)
            mem_q[wr_q] <= in_data_in;
    end

    // pointers and fill level
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            wr_q <= '0;
            rd_q <= '0;
            fill_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= wr_q + 1'b1;
            if (pop)
                rd_q <= rd_q + 1'b1;
            if (push && !pop)
                fill_q <= fill_q + 1'b1;
            else if (pop && !push)
                fill_q <= fill_q - 1'b1;
        end
    end
endmodule

// ===== hw/fpcl_pkg.sv
// constants, encodings and shared decode for the fast parallel config loader
// assumes a 125 MHz core clock on both ends and a shared link interface
//
// Overview of operation
// - device spends 1, 4 or 8 clocks per word
// - host clock rate is ratio times word rate
// - host stops clock ratio-1 cycles after last word
// - request low starts a new configuration cycle
// - status held low through power-on delay, then released
// - power-on delay fast 4-12 ms, standard 100-300 ms
// - mode select strap picks fast or standard delay
// - load complete low through the whole transfer
// - load complete rises only after error-free full stream
// - host sends two falling edges after load complete
// - device ignores clock after load; host keeps driving (here the host parks the clock low after the two closing falls)
// - init-done pin driven low once option loaded
// - x8 and x16 modes use only low lines
// - oscillator init reaches user mode in 175-437 us
// - user init clock: 4 periods wait, 8576 edges
// - data pins become user I/O after configuration
// - chain enable output unused unless chaining devices
package fpcl_pkg;
    localparam int unsigned WORD_W = 32;
    localparam int unsigned CORE_CLK_MHZ = 125;
    // power-on delay window in microseconds
    localparam int unsigned POR_FAST_MIN_US = 4000;
    localparam int unsigned POR_FAST_MAX_US = 12000;
    localparam int unsigned POR_STD_MIN_US = 100000;
    localparam int unsigned POR_STD_MAX_US = 300000;
    localparam int unsigned POR_FAST_CYC = POR_FAST_MIN_US * CORE_CLK_MHZ;
    localparam int unsigned POR_STD_CYC = POR_STD_MIN_US * CORE_CLK_MHZ;
    // oscillator initialisation window in microseconds
    localparam int unsigned INIT_MIN_US = 175;
    localparam int unsigned INIT_MAX_US = 437;
    localparam int unsigned OSC_INIT_CYC = INIT_MIN_US * CORE_CLK_MHZ;
    // user init clock figures
    localparam int unsigned USR_INIT_EDGES = 8576;
    localparam int unsigned UCLK_WAIT_PERIODS = 4;
    localparam int unsigned FALLS_TO_INIT = 2;
    // host clock divider: half period in core cycles
    localparam int unsigned HOST_HALF_CYC = 8;
    // mode select strap fields
    localparam int unsigned MODE_FAST_BIT = 0;
    localparam int unsigned MODE_WIDTH_LSB = 1;
    localparam logic [1:0] WIDTH_X8 = 2'h0;
    localparam logic [1:0] WIDTH_X16 = 2'h1;
    // option bits carried in the first configuration word
    localparam int unsigned OPT_INITDONE_BIT = 0;
    localparam int unsigned OPT_USRCLK_BIT = 1;
    // synchroniser bit positions above the data lines
    localparam int unsigned SY_CCLK = WORD_W;
    localparam int unsigned SY_REQ = WORD_W + 1;
    localparam int unsigned SY_UCLK = WORD_W + 2;
    localparam int unsigned SYNC_W = WORD_W + 3;
    localparam logic [3:0] RATIO_PLAIN = 4'h1;
    localparam logic [3:0] RATIO_SECURE = 4'h4;
    localparam logic [3:0] RATIO_COMPRESS = 4'h8;

    // clocks per data word for the chosen feature set
    function automatic logic [3:0] clk_ratio(input logic compress, input logic secure);
        if (compress)
            return RATIO_COMPRESS;
        if (secure)
            return RATIO_SECURE;
        return RATIO_PLAIN;
    endfunction

    // mask of data lines that carry configuration data
    function automatic logic [WORD_W-1:0] width_mask(input logic [1:0] width);
        if (width == WIDTH_X8)
            return 32'h0000_00FF;
        if (width == WIDTH_X16)
            return 32'h0000_FFFF;
        return 32'hFFFF_FFFF;
    endfunction
endpackage

// ===== tb/fpcl_bench.sv
// testbench joining host and device ends over the link
// assumes shortened power-on and init counts set below
`timescale 1ns/100ps
module fpcl_bench;
    import fpcl_pkg::*;
    logic clk = 0, rst = 1, start = 0, cmp = 0, sec = 0, fast = 1;
    logic wlast = 0, wval = 0, rdy = 0, wv, wrdy, um, er, dn, fl, bsy;
    logic [1:0] wid = 0;
    logic [31:0] wdata = 0, nw = 1, wout, uio;
    int err_total = 0, compares = 0;
    fpcl_link_if link ();
    fpcl_device #(.POR_FAST_CYC(50), .POR_STD_CYC(100), .OSC_INIT_CYC(40),
        .USR_INIT_EDGES(6)) fpcl_device_i (.CORE_CLK_IN(clk), .RESET_IN(rst), .LINK(link),
        .MODE_SELECT_IN({wid, fast}), .COMPRESS_IN(cmp), .SECURE_IN(sec),
        .CONFIG_WORDS_IN(nw), .WORD_OUT(wout), .WORD_VALID_OUT(wv), .WORD_READY_IN(rdy),
        .USER_MODE_OUT(um), .ERROR_OUT(er), .USER_IO_OUT(uio));
    fpcl_host fpcl_host_i (.CORE_CLK_IN(clk), .RESET_IN(rst), .LINK(link),
        .START_IN(start), .COMPRESS_IN(cmp), .SECURE_IN(sec), .WIDTH_IN(wid),
        .WORD_IN(wdata), .WORD_LAST_IN(wlast), .WORD_VALID_IN(wval),
        .WORD_READY_OUT(wrdy), .BUSY_OUT(bsy), .DONE_OUT(dn), .FAULT_OUT(fl));
    fpcl_link_props fpcl_link_props_i (.CORE_CLK_IN(clk), .RESET_IN(rst),
        .reconfig_request_n(link.reconfig_request_n), .load_complete(link.load_complete),
        .status_n(link.status_n), .init_done_n(link.init_done_n),
        .chain_enable_out_n(link.chain_enable_out_n));
    ////////////////////////////////////////////////////////////
    // clock and helpers
    always #4 clk = ~clk;
    function automatic logic [31:0] lanes(input logic [31:0] w);
        return wid == 2'h0 ? w & 32'h0000_00FF : wid == 2'h1 ? w & 32'h0000_FFFF : w;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (err_total == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // one full load: feed words, drain them at random pace, wait for user mode
    task automatic load(input int n);
        logic [31:0] q[$];
        int k;
        nw = n;
        @(posedge clk) #1 start = 1;
        @(posedge clk) #1 start = 0;
        fork
            begin
                for (int i = 0; i < n; i++)
                begin
                    wdata = $urandom;
                    q.push_back(lanes(wdata));
                    wlast = (i == n - 1);
                    wval = 1;
                    @(posedge clk);
                    while (wrdy !== 1'b1)
                        @(posedge clk);
                    #1;
                end
                wval = 0;
            end
            for (int g = 0; g < n;)
            begin
                @(posedge clk);
                if (wv === 1'b1 && rdy === 1'b1)
                begin
                    check(wout, q.pop_front());
                    g++;
                end
                #1 rdy = $urandom;
            end
        join
        k = 0;
        while (um !== 1'b1 && k < 4000)
        begin
            @(posedge clk);
            k++;
        end
        #1 check({link.init_done_n, link.load_complete, link.status_n,
            link.reconfig_request_n, dn, er, fl, um, bsy}, 32'h1F2);
        check(uio, lanes(wdata));
    endtask
    ////////////////////////////////////////////////////////////
    // every ratio and width, the single word load first
    initial
    begin
        void'($urandom(72088));
        repeat (4) @(posedge clk);
        #1 rst = 0;
        for (int m = 0; m < 12; m++)
        begin
            {wid, sec, cmp} = m[3:0];
            load(m == 0 ? 1 : 2 + $urandom % 5);
        end
        // mid-run reset with the standard power-on delay selected
        fast = 0;
        rst = 1;
        repeat (4) @(posedge clk);
        #1 rst = 0;
        repeat (60) @(posedge clk);
        #1 check(link.status_n, 32'h0);
        load(1);
        finish_test();
    end
    // watchdog against a hung handshake
    initial
    begin
        #400000;
        err_total++;
        finish_test();
    end
endmodule

// ===== tb/fpcl_link_props.sv
// checker for the link between configuration host and device
// assumes it watches the shared link wires in the core clock domain
`timescale 1ns/100ps
module fpcl_link_props (
    input wire logic CORE_CLK_IN,
    input wire logic RESET_IN,
    input wire logic reconfig_request_n,
    input wire logic load_complete,
    input wire logic status_n,
    input wire logic init_done_n,
    input wire logic chain_enable_out_n
);
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (RESET_IN);
    ////////////////////////////////////////////////////////////
    // device side relations on the link
    property p_por; $fell(RESET_IN) |-> !status_n [*8]; endproperty
    a_por: assert property (p_por) else $error("status released early");
    property p_lc_ok; $rose(load_complete) |-> status_n; endproperty
    a_lc_ok: assert property (p_lc_ok) else $error("load done in error");
    property p_lc_drop; !reconfig_request_n |-> ##[1:8] !load_complete; endproperty
    a_lc_drop: assert property (p_lc_drop) else $error("load done stuck");
    property p_req; $fell(reconfig_request_n) |-> ##[0:8] !status_n; endproperty
    a_req: assert property (p_req) else $error("request not seen");
    property p_init; $rose(init_done_n) |-> load_complete; endproperty
    a_init: assert property (p_init) else $error("init done early");
    property p_hold; load_complete && reconfig_request_n |=> load_complete; endproperty
    a_hold: assert property (p_hold) else $error("load done fell");
    property p_rel; $rose(status_n) |-> reconfig_request_n; endproperty
    a_rel: assert property (p_rel) else $error("status rose in request");
    property p_chain; 1'b1 |-> chain_enable_out_n; endproperty
    a_chain: assert property (p_chain) else $error("chain line driven");
    // main scenarios seen
    c_load: cover property ($rose(load_complete));
    c_reconf: cover property ($fell(reconfig_request_n));
    c_init: cover property ($rose(init_done_n));
endmodule
